//--- bench/ecw_cfg_space_model.sv
/*
 * model of the rest of config space behind the forwarded window port.
 * assumes one forwarded access at a time, registered on i_clk_sys.
 */
`timescale 1ns/1ps
module ecw_cfg_space_model
(
   input  wire logic               i_clk_sys,
   input  wire logic               i_ext_req,
   input  wire logic               i_ext_wr,
   input  wire ecw_pkg::ecw_addr_t i_ext_addr,
   input  wire logic [3:0]         i_ext_be,
   input  wire logic [31:0]        i_ext_wdata,
   input  wire logic               i_slow,
   output logic                    o_ext_ack,
   output logic [31:0]             o_ext_rdata
);
   import ecw_pkg::*;
   logic [31:0] mem [0:1023];
   logic        pend;
   logic [3:0]  wait_cnt;
   initial
   begin
      foreach (mem[k]) mem[k] = 32'h0000_0000;
      pend = 1'b0;
      o_ext_ack = 1'b0;
      o_ext_rdata = 32'h5A5A_5A5A;
   end
   // answer after 1 or 7 cycles; outside the answer the data toggles so it is never trusted
   always @(posedge i_clk_sys)
   begin
      o_ext_ack <= 1'b0;
      o_ext_rdata <= ~o_ext_rdata;
      if (i_ext_req)
      begin
         pend <= 1'b1;
         wait_cnt <= i_slow ? 4'h6 : 4'h0;
      end
      else if (pend && wait_cnt != 4'h0)
         wait_cnt <= wait_cnt - 4'h1;
      else if (pend)
      begin
         pend <= 1'b0;
         o_ext_ack <= 1'b1;
         o_ext_rdata <= mem[i_ext_addr[11:2]];
         for (int b = 0; b < 4; b++)
            if (i_ext_wr && i_ext_be[b])
               mem[i_ext_addr[11:2]][8*b +: 8] <= i_ext_wdata[8*b +: 8];
      end
   end
endmodule

//--- bench/ecw_top_tb_top.sv
/*
 * self-checking bench for the config window and error status slice.
 * assumes the forwarded port is served by ecw_cfg_space_model.
 */
`timescale 1ns/1ps
module ecw_top_tb_top;
   import ecw_pkg::*;
   logic clk, rstn, por_n, req, wr, sm, lock, slow;
   logic [3:0] be;
   ecw_addr_t addr;
   logic [31:0] wd, rd;
   logic [8:0] ev;
   logic ack, busy, x_req, x_wr, x_ack, bz;
   ecw_addr_t x_addr;
   logic [3:0] x_be;
   logic [31:0] cfg_rd, x_wd, x_rd;
   int err_count, samples_checked, cyc;
   int pos [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

   ecw_top dut (.i_clk_sys(clk), .i_rstn(rstn), .i_por_n(por_n), .i_ce(1'b1),
      .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_smbus(sm), .i_cfg_addr(addr),
      .i_cfg_be(be), .i_cfg_wdata(wd), .i_cfg_lock(lock), .o_cfg_ack(ack),
      .o_cfg_busy(busy), .o_cfg_rdata(cfg_rd), .o_ext_req(x_req), .o_ext_wr(x_wr),
      .o_ext_addr(x_addr), .o_ext_be(x_be), .o_ext_wdata(x_wd), .i_ext_ack(x_ack),
      .i_ext_rdata(x_rd), .i_link_protocol_fault(ev[0]), .i_surprise_link_loss(ev[1]),
      .i_poisoned_tlp(ev[2]), .i_credit_protocol_fault(ev[3]),
      .i_stray_completion(ev[4]), .i_rx_overflow(ev[5]), .i_bad_format(ev[6]),
      .i_ecrc_error(ev[7]), .i_unsupported_request(ev[8]));
   ecw_cfg_space_model far (.i_clk_sys(clk), .i_ext_req(x_req), .i_ext_wr(x_wr),
      .i_ext_addr(x_addr), .i_ext_be(x_be), .i_ext_wdata(x_wd), .i_slow(slow),
      .o_ext_ack(x_ack), .o_ext_rdata(x_rd));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic final_report();
      if (err_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard: the whole run needs well under 3000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one access; request dropped after the taking edge, answer awaited under a bound
   task automatic cfg(input logic w, s, input ecw_addr_t a, input logic [3:0] b,
      input logic [31:0] d);
      int n;
      n = 0;
      @(negedge clk);
      req = 1'b1; wr = w; sm = s; addr = a; be = b; wd = d;
      @(negedge clk);
      req = 1'b0;
      bz = busy;
      while (ack !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 40)
         chk("cfg_ack", 32'h1, 32'h0);
      rd = cfg_rd;
   endtask
   task automatic rdc(input string nm, input ecw_addr_t a, input logic s,
      input logic [31:0] e);
      cfg(1'b0, s, a, 4'hF, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic do_reset(input logic pwr);
      @(negedge clk);
      rstn = 1'b0; por_n = ~pwr;
      repeat (5) @(negedge clk);
      rstn = 1'b1; por_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask

   // scenario: reset values of the header, status and pointer
   task automatic t_reset_values();
      rdc("cap_hdr", 12'h100, 1'b0, 32'h2001_0001);
      rdc("status", 12'h104, 1'b0, 32'h0000_0000);
      rdc("pointer", 12'h0F8, 1'b0, 32'h0000_0000);
   endtask
   // scenario: pointer fields, reserved bits, byte enables on a direct write
   task automatic t_pointer();
      cfg(1'b1, 1'b0, 12'h0F8, 4'hF, 32'hFFFF_FFFF);
      rdc("pointer", 12'h0F8, 1'b0, 32'h0000_0FFC);
      cfg(1'b1, 1'b0, 12'h0F8, 4'h1, 32'h0000_0000);
      rdc("pointer", 12'h0F8, 1'b0, 32'h0000_0F00);
   endtask
   // scenario: forwarded window write and read, fast and slow far side
   task automatic t_forward();
      cfg(1'b1, 1'b0, 12'h0F8, 4'hF, 32'h0000_0314);
      slow = 1'b1;
      cfg(1'b1, 1'b0, 12'h0FC, 4'h6, 32'hA5A5_A5A5);
      chk("ext_addr", 32'h314, {20'h0, x_addr});
      chk("ext_be", 32'h6, {28'h0, x_be});
      chk("ext_wr", 32'h1, {31'h0, x_wr});
      chk("busy", 32'h1, {31'h0, bz});
      slow = 1'b0;
      rdc("window", 12'h0FC, 1'b0, 32'h00A5_A500);
      chk("ext_rd", 32'h0, {31'h0, x_wr});
      rdc("smb_win", 12'h0FC, 1'b1, 32'h0000_0000);
      chk("busy_loc", 32'h0, {31'h0, bz});
      cfg(1'b1, 1'b1, 12'h0FC, 4'hF, 32'h1234_5678);
      rdc("window", 12'h0FC, 1'b0, 32'h00A5_A500);
   endtask
   // scenario: window aimed at itself, at the pointer, at the header
   task automatic t_self();
      cfg(1'b1, 1'b0, 12'h0F8, 4'hF, 32'h0000_00FC);
      cfg(1'b1, 1'b0, 12'h0FC, 4'hF, 32'hFFFF_FFFF);
      rdc("win_self", 12'h0FC, 1'b0, 32'h0000_0000);
      rdc("pointer", 12'h0F8, 1'b0, 32'h0000_00FC);
      cfg(1'b1, 1'b0, 12'h0F8, 4'hF, 32'h0000_00F8);
      cfg(1'b1, 1'b0, 12'h0FC, 4'hF, 32'h0000_0100);
      rdc("pointer", 12'h0F8, 1'b0, 32'h0000_0100);
      lock = 1'b0;
      cfg(1'b1, 1'b0, 12'h100, 4'hF, 32'hABCF_FFFF);
      rdc("win_cap", 12'h0FC, 1'b0, 32'hABC1_0001);
      lock = 1'b1;
      cfg(1'b1, 1'b0, 12'h100, 4'hF, 32'h0000_0000);
      rdc("cap_lock", 12'h100, 1'b0, 32'hABC1_0001);
   endtask
   // scenario: each event sets its own bit; zero keeps it, one clears it
   task automatic t_events();
      for (int i = 0; i < 9; i++)
      begin
         @(negedge clk);
         ev = 9'h001 << i;
         @(negedge clk);
         ev = 9'h000;
         rdc("status", 12'h104, 1'b0, 32'h1 << pos[i]);
         cfg(1'b1, 1'b0, 12'h104, 4'hF, 32'h0000_0000);
         rdc("st_keep", 12'h104, 1'b0, 32'h1 << pos[i]);
         cfg(1'b1, 1'b0, 12'h104, 4'hF, 32'h1 << pos[i]);
         rdc("st_clr", 12'h104, 1'b0, 32'h0);
      end
      // an event in the very cycle of a one-clear must survive it
      @(negedge clk);
      ev = 9'h004;
      cfg(1'b1, 1'b0, 12'h104, 4'hF, 32'h0000_1000);
      ev = 9'h000;
      rdc("st_set_win", 12'h104, 1'b0, 32'h0000_1000);
      cfg(1'b1, 1'b0, 12'h104, 4'hF, 32'h0000_1000);
      rdc("st_clr2", 12'h104, 1'b0, 32'h0);
   endtask
   // scenario: all events, fixed-zero bits, warm reset keeps status, power-on clears
   task automatic t_sticky();
      @(negedge clk);
      ev = 9'h1FF;
      @(negedge clk);
      ev = 9'h000;
      rdc("st_all", 12'h104, 1'b0, 32'h001F_3030);
      do_reset(1'b0);
      rdc("st_warm", 12'h104, 1'b0, 32'h001F_3030);
      rdc("ptr_warm", 12'h0F8, 1'b0, 32'h0000_0000);
      rdc("cap_warm", 12'h100, 1'b0, 32'h2001_0001);
      do_reset(1'b1);
      rdc("st_por", 12'h104, 1'b0, 32'h0000_0000);
   endtask

   initial
   begin
      rstn = 1'b0; por_n = 1'b0; req = 1'b0; wr = 1'b0; sm = 1'b0; lock = 1'b1;
      slow = 1'b0; be = 4'h0; addr = 12'h000; wd = 32'h0; ev = 9'h000;
      err_count = 0; samples_checked = 0; cyc = 0;
      repeat (5) @(negedge clk);
      rstn = 1'b1; por_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset_values();
      t_pointer();
      t_forward();
      t_self();
      t_events();
      t_sticky();
      final_report();
   end
endmodule

//--- src/ecw_defs.svh
/*
 * offsets, field positions, reset values and fixed codes of the
 * extended config window and error status slice.
 * assumes byte addresses within a 4 KiB configuration space.
 */
`ifndef ECW_DEFS_SVH
`define ECW_DEFS_SVH

// register byte offsets
`define ECW_OFS_PTR        12'h0F8
`define ECW_OFS_WIN        12'h0FC
`define ECW_OFS_CAP        12'h100
`define ECW_OFS_UES        12'h104

// pointer register fields
`define ECW_PTR_IDX_LSB    2
`define ECW_PTR_IDX_MSB    7
`define ECW_PTR_EXT_LSB    8
`define ECW_PTR_EXT_MSB    11
`define ECW_PTR_IDX_RST    6'h00
`define ECW_PTR_EXT_RST    4'h0

// capability header fields
`define ECW_CAP_CODE       16'h0001
`define ECW_CAP_REV        4'h1
`define ECW_CAP_NEXT_RST   12'h200
`define ECW_CAP_NEXT_LSB   20

// error status: implemented bits and their positions
`define ECW_UES_RST        32'h0000_0000
`define ECW_UES_IMPL       32'h001F_3031
`define ECW_BIT_OBSOLETE   0
`define ECW_BIT_LINK_PROTO 4
`define ECW_BIT_LINK_LOSS  5
`define ECW_BIT_POISONED   12
`define ECW_BIT_CREDIT     13
`define ECW_BIT_CPL_TO     14
`define ECW_BIT_CPL_ABORT  15
`define ECW_BIT_STRAY_CPL  16
`define ECW_BIT_RX_OVF     17
`define ECW_BIT_BAD_FMT    18
`define ECW_BIT_ECRC       19
`define ECW_BIT_UNSUP_REQ  20

`endif

//--- src/ecw_pkg.sv
/*
 * types shared by the extended config window slice.
 * assumes ecw_defs.svh holds all numeric constants.
 */
package ecw_pkg;
   typedef logic [11:0] ecw_addr_t;
   typedef enum logic {ECW_IDLE, ECW_EXT_WAIT} ecw_state_t;
endpackage

//--- src/ecw_sticky_bit.sv
/*
 * one write-one-to-clear sticky status bit.
 * assumes i_por_n is the synchronised power-on reset, active low.
 */
`timescale 1ns/1ps
`include "ecw_defs.svh"
module ecw_sticky_bit
(
   input  wire logic i_clk_sys,
   input  wire logic i_ce,
   input  wire logic i_por_n,
   input  wire logic i_set,
   input  wire logic i_clr,
   output logic      o_q
);
   // only power-on reset touches it; a set in the clear cycle wins
   always_ff @(posedge i_clk_sys or negedge i_por_n)
   begin
      if (!i_por_n)
         o_q <= 1'b0;
      else if (i_ce)
         o_q <= i_set | (o_q & ~i_clr);
   end
endmodule

//--- src/ecw_top.sv
/*
 * config-space slice: indirect pointer and window, error reporting
 * capability header and sticky uncorrectable error status.
 * assumes one config requester at a time, a separate power-on reset
 * during which i_rstn is also asserted, and that the rest of config
 * space answers forwarded window accesses on the o_ext port.
 */
`timescale 1ns/1ps
`include "ecw_defs.svh"

// How it works
// - pointer bits 7:2 hold dword index
// - pointer bits 11:8 hold extended index
// - window read returns selected register value
// - window write updates selected register
// - window byte enables pass to target
// - window pointing at itself: zero, discard
// - window pointing at pointer rewrites pointer
// - SMBus window access reads zero, no effect
// - header: code 0x1, next link 0x200
// - header revision field reads one
// - bit 0 obsolete sticky one-to-clear
// - bit 4 link protocol fault
// - bit 5 surprise link loss
// - bit 12 poisoned packet received
// - bit 13 credit protocol fault
// - bit 14 completion timeout always zero
// - bit 15 completer abort always zero
// - bit 16 stray completion received
// - bit 17 receive overflow
// - bit 18 malformed packet received
// - bit 19 end-to-end CRC error
// - bit 20 unsupported request
module ecw_top
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rstn,
   input  wire logic              i_por_n,
   input  wire logic              i_ce,
   input  wire logic              i_cfg_req,
   input  wire logic              i_cfg_wr,
   input  wire logic              i_cfg_smbus,
   input  wire ecw_pkg::ecw_addr_t i_cfg_addr,
   input  wire logic [3:0]        i_cfg_be,
   input  wire logic [31:0]       i_cfg_wdata,
   input  wire logic              i_cfg_lock,
   output logic                   o_cfg_ack,
   output logic                   o_cfg_busy,
   output logic [31:0]            o_cfg_rdata,
   output logic                   o_ext_req,
   output logic                   o_ext_wr,
   output ecw_pkg::ecw_addr_t     o_ext_addr,
   output logic [3:0]             o_ext_be,
   output logic [31:0]            o_ext_wdata,
   input  wire logic              i_ext_ack,
   input  wire logic [31:0]       i_ext_rdata,
   input  wire logic              i_link_protocol_fault,
   input  wire logic              i_surprise_link_loss,
   input  wire logic              i_poisoned_tlp,
   input  wire logic              i_credit_protocol_fault,
   input  wire logic              i_stray_completion,
   input  wire logic              i_rx_overflow,
   input  wire logic              i_bad_format,
   input  wire logic              i_ecrc_error,
   input  wire logic              i_unsupported_request
);
   import ecw_pkg::*;

   localparam logic [31:0] UES_IMPL = `ECW_UES_IMPL;

   logic [1:0]  rst_sync_q;
   logic [1:0]  por_sync_q;
   logic        rst_n;
   logic        por_n;
   ecw_state_t  st_q;
   logic [5:0]  ptr_idx_q;
   logic [3:0]  ptr_ext_q;
   logic [11:0] cap_next_q;
   logic        ext_wr_q;
   logic [31:0] ues_q;
   logic [31:0] ues_set;

   // reset release through two flops; async assert, clocked release
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         rst_sync_q <= 2'h0;
      else if (i_ce)
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // power-on reset gets its own release pair for the sticky bits
   always_ff @(posedge i_clk_sys or negedge i_por_n)
   begin
      if (!i_por_n)
         por_sync_q <= 2'h0;
      else if (i_ce)
         por_sync_q <= {por_sync_q[0], 1'b1};
   end

   assign rst_n = rst_sync_q[1];
   assign por_n = por_sync_q[1];

   // request decode; the window is only a window for non-SMBus callers
   wire       acc      = i_ce & i_cfg_req & (st_q == ECW_IDLE);
   wire       dir_win  = ({i_cfg_addr[11:2], 2'h0} == `ECW_OFS_WIN);
   wire       is_ind   = dir_win & ~i_cfg_smbus;
   wire [11:0] ptr_addr = {ptr_ext_q, ptr_idx_q, 2'h0};
   wire [11:0] tgt      = is_ind ? ptr_addr : {i_cfg_addr[11:2], 2'h0};
   wire       null_acc = dir_win & (i_cfg_smbus | (ptr_addr == `ECW_OFS_WIN));
   wire       hit_ptr  = ~null_acc & (tgt == `ECW_OFS_PTR);
   wire       hit_cap  = ~null_acc & (tgt == `ECW_OFS_CAP);
   wire       hit_ues  = ~null_acc & (tgt == `ECW_OFS_UES);
   wire       is_local = hit_ptr | hit_cap | hit_ues;
   wire       go_ext   = acc & is_ind & ~null_acc & ~is_local;
   wire       wr_en    = acc & i_cfg_wr;

   // register images; unused and reserved bits are constant zero
   wire [31:0] rd_ptr = {20'h0, ptr_ext_q, ptr_idx_q, 2'h0};
   wire [31:0] rd_cap = {cap_next_q, `ECW_CAP_REV, `ECW_CAP_CODE};
   wire [31:0] rd_loc = hit_ptr ? rd_ptr :
                        hit_cap ? rd_cap :
                        hit_ues ? ues_q  : 32'h0000_0000;

   // pointer fields, written directly or through the window onto itself
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_idx_q <= `ECW_PTR_IDX_RST;
         ptr_ext_q <= `ECW_PTR_EXT_RST;
      end
      else if (i_ce && wr_en && hit_ptr)
      begin
         if (i_cfg_be[0])
            ptr_idx_q <= i_cfg_wdata[`ECW_PTR_IDX_MSB:`ECW_PTR_IDX_LSB];
         if (i_cfg_be[1])
            ptr_ext_q <= i_cfg_wdata[`ECW_PTR_EXT_MSB:`ECW_PTR_EXT_LSB];
      end
   end

   // next link is writable only while the config lock is open
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cap_next_q <= `ECW_CAP_NEXT_RST;
      else if (i_ce && wr_en && hit_cap && !i_cfg_lock)
      begin
         if (i_cfg_be[2])
            cap_next_q[3:0] <= i_cfg_wdata[23:20];
         if (i_cfg_be[3])
            cap_next_q[11:4] <= i_cfg_wdata[31:24];
      end
   end

   // event inputs onto status positions; bit 0 has no source
   always_comb
   begin
      ues_set                      = 32'h0000_0000;
      ues_set[`ECW_BIT_LINK_PROTO] = i_link_protocol_fault;
      ues_set[`ECW_BIT_LINK_LOSS]  = i_surprise_link_loss;
      ues_set[`ECW_BIT_POISONED]   = i_poisoned_tlp;
      ues_set[`ECW_BIT_CREDIT]     = i_credit_protocol_fault;
      ues_set[`ECW_BIT_STRAY_CPL]  = i_stray_completion;
      ues_set[`ECW_BIT_RX_OVF]     = i_rx_overflow;
      ues_set[`ECW_BIT_BAD_FMT]    = i_bad_format;
      ues_set[`ECW_BIT_ECRC]       = i_ecrc_error;
      ues_set[`ECW_BIT_UNSUP_REQ]  = i_unsupported_request;
   end

   // one sticky cell per implemented bit, the rest tie to zero
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1)
      begin : g_ues
         if (UES_IMPL[gi])
         begin : g_cell
            wire clr = wr_en & hit_ues & i_cfg_be[gi/8] & i_cfg_wdata[gi];
            ecw_sticky_bit u_bit
            (
               .i_clk_sys (i_clk_sys),
               .i_ce      (i_ce),
               .i_por_n   (por_n),
               .i_set     (ues_set[gi]),
               .i_clr     (clr),
               .o_q       (ues_q[gi])
            );
         end
         else
         begin : g_zero
            assign ues_q[gi] = 1'b0;
         end
      end
   endgenerate

   // access sequencer: local answers next cycle, forwarded ones wait
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q        <= ECW_IDLE;
         o_cfg_ack   <= 1'b0;
         o_cfg_busy  <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
         o_ext_req   <= 1'b0;
         ext_wr_q    <= 1'b0;
         o_ext_addr  <= 12'h000;
         o_ext_be    <= 4'h0;
         o_ext_wdata <= 32'h0000_0000;
      end
      else if (i_ce)
      begin
         o_cfg_ack <= 1'b0;
         o_ext_req <= 1'b0;
         case (st_q)
            ECW_IDLE:
            begin
               if (go_ext)
               begin
                  st_q        <= ECW_EXT_WAIT;
                  o_cfg_busy  <= 1'b1;
                  o_ext_req   <= 1'b1;
                  ext_wr_q    <= i_cfg_wr;
                  o_ext_addr  <= ptr_addr;
                  o_ext_be    <= i_cfg_be;
                  o_ext_wdata <= i_cfg_wdata;
               end
               else if (acc)
               begin
                  o_cfg_ack   <= 1'b1;
                  o_cfg_rdata <= i_cfg_wr ? 32'h0000_0000 : rd_loc;
               end
            end
            ECW_EXT_WAIT:
            begin
               if (i_ext_ack)
               begin
                  st_q        <= ECW_IDLE;
                  o_cfg_busy  <= 1'b0;
                  o_cfg_ack   <= 1'b1;
                  o_cfg_rdata <= ext_wr_q ? 32'h0000_0000 : i_ext_rdata;
               end
            end
            default:
               st_q <= ECW_IDLE;
         endcase
      end
   end

   assign o_ext_wr = ext_wr_q;

   // checks
   sequence s_acc_rd(logic [11:0] a);
      acc && !i_cfg_wr && !i_cfg_smbus && ({i_cfg_addr[11:2], 2'h0} == a);
   endsequence

   sequence s_ack_zero;
      o_cfg_ack && (o_cfg_rdata == 32'h0000_0000);
   endsequence

   property p_idx_write;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (acc && i_cfg_wr && !i_cfg_smbus && i_cfg_be[0] && tgt == `ECW_OFS_PTR && !dir_win)
      |=> (ptr_idx_q == $past(i_cfg_wdata[7:2]));
   endproperty
   a_idx_write: assert property (p_idx_write) else $error("pointer index not written");

   property p_ext_write;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (acc && i_cfg_wr && i_cfg_be[1] && hit_ptr && is_ind)
      |=> (ptr_ext_q == $past(i_cfg_wdata[11:8])) && o_cfg_ack;
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("window write missed pointer");

   property p_fwd;
      @(posedge i_clk_sys) disable iff (!rst_n)
      go_ext |=> o_ext_req && (o_ext_be == $past(i_cfg_be)) && (o_ext_addr == $past(ptr_addr))
                 && (o_ext_wr == $past(i_cfg_wr)) ##1 !o_ext_req;
   endproperty
   a_fwd: assert property (p_fwd) else $error("window access not forwarded");

   property p_ext_ret;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (i_ce && st_q == ECW_EXT_WAIT && i_ext_ack && !ext_wr_q)
      |=> o_cfg_ack && (o_cfg_rdata == $past(i_ext_rdata));
   endproperty
   a_ext_ret: assert property (p_ext_ret) else $error("forwarded read data lost");

   property p_self_zero;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (s_acc_rd(`ECW_OFS_WIN) and (ptr_addr == `ECW_OFS_WIN)) |=> s_ack_zero ##1 !o_cfg_ack;
   endproperty
   a_self_zero: assert property (p_self_zero) else $error("self window read not zero");

   property p_smbus;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (acc && i_cfg_smbus && dir_win) |=> s_ack_zero and (!o_ext_req && $stable(ptr_idx_q));
   endproperty
   a_smbus: assert property (p_smbus) else $error("smbus window access had effect");

   property p_cap_rd;
      @(posedge i_clk_sys) disable iff (!rst_n)
      s_acc_rd(`ECW_OFS_CAP) |=> o_cfg_ack && (o_cfg_rdata[19:0] == 20'h10001);
   endproperty
   a_cap_rd: assert property (p_cap_rd) else $error("capability header wrong");

   property p_fixed_zero;
      @(posedge i_clk_sys) disable iff (!por_n)
      (ues_q[15:14] == 2'h0) && (ues_q[11:6] == 6'h00) && (ues_q[3:1] == 3'h0)
      && (ues_q[31:21] == 11'h000);
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("hardwired status bit set");

   property p_set_wins;
      @(posedge i_clk_sys) disable iff (!por_n)
      (i_ce && i_poisoned_tlp) |=> ues_q[`ECW_BIT_POISONED];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("poisoned event lost");

   property p_clear;
      @(posedge i_clk_sys) disable iff (!por_n)
      (wr_en && hit_ues && i_cfg_be[2] && i_cfg_wdata[17] && !i_rx_overflow)
      |=> !ues_q[17];
   endproperty
   a_clear: assert property (p_clear) else $error("one-to-clear failed");

   property p_cap_lock;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (wr_en && hit_cap && i_cfg_lock) |=> $stable(cap_next_q);
   endproperty
   a_cap_lock: assert property (p_cap_lock) else $error("locked next link changed");

   property p_busy_fwd;
      @(posedge i_clk_sys) disable iff (!rst_n)
      go_ext |=> o_cfg_busy && !o_cfg_ack;
   endproperty
   a_busy_fwd: assert property (p_busy_fwd) else $error("forward not marked busy");

   property p_local_ack;
      @(posedge i_clk_sys) disable iff (!rst_n)
      (acc && !go_ext) |=> o_cfg_ack && !o_cfg_busy;
   endproperty
   a_local_ack: assert property (p_local_ack) else $error("local access not answered");
endmodule
